// file: rtl/ire_pkg.sv
package ire_pkg;

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  localparam int unsigned IRE_BIT_TICKS = 16;
  localparam int unsigned IRE_CNT_W = 4;
  localparam logic [3:0] IRE_CNT_FIRST = 4'h0;
  localparam logic [3:0] IRE_CNT_LAST = 4'hf;
  localparam logic [3:0] IRE_TX_PULSE_FIRST = 4'h7;
  localparam logic [3:0] IRE_TX_PULSE_LAST = 4'h9;
  localparam logic [3:0] IRE_RX_UPDATE_CNT = 4'h8;
  localparam logic [3:0] IRE_RX_WIN_OPEN_CNT = 4'hc;
  localparam logic [3:0] IRE_CAP_SAMPLE_CNT = 4'h8;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int unsigned IRE_DIV_W = 16;
  localparam int unsigned IRE_FIFO_WIDTH = 1;
  localparam int unsigned IRE_FIFO_DEPTH = 8;
  localparam logic IRE_LINE_IDLE = 1'b1;
  localparam logic IRE_MOD_IDLE = 1'b0;

  // ----------------------------------------
  // Decoder states
  // ----------------------------------------
  typedef enum logic [0:0] {
    ire_rx_idle,
    ire_rx_track
  } ire_rx_state_t;

endpackage

// file: rtl/ire_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ire_fifo #(
  parameter int unsigned WIDTH = ire_pkg::IRE_FIFO_WIDTH,
  parameter int unsigned DEPTH = ire_pkg::IRE_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_param
    $error("ire_fifo needs WIDTH >= 1 and DEPTH >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [PTR_W:0] count_reg, count_next;
  logic push, pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (push) begin
        mem_next[wr_ptr_reg] = in_data;
        wr_ptr_next = ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_next = ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ire_endec.sv
`timescale 1ns/1ps
`default_nettype none
module ire_endec #(
  parameter int unsigned DIV_W = ire_pkg::IRE_DIV_W,
  parameter int unsigned FIFO_DEPTH = ire_pkg::IRE_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic infrared_codec_enable,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic uart_txd,
  output logic uart_rxd,
  output logic txd_pin,
  input wire logic rxd_pin,
  output logic baud_tick,
  output logic tx_fifo_ready,
  output logic tx_sending,
  output logic rx_tracking
);

  if (DIV_W < 1 || DIV_W > 32 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("ire_endec needs 1 <= DIV_W <= 32 and FIFO_DEPTH >= 2");
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Counters wrap naturally at sixteen
  function automatic logic [3:0] tick_inc(input logic [3:0] c);
    tick_inc = c + 4'h1;
  endfunction

  function automatic logic in_range(input logic [3:0] c, input logic [3:0] lo, input logic [3:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction

  logic en;
  logic ir_pulse_in;
  logic ir_modulated_out;
  logic tx_busy;

  assign en = infrared_codec_enable;
  assign ir_pulse_in = rxd_pin;

  // ----------------------------------------
  // Baud tick divider
  // ----------------------------------------
  logic [DIV_W-1:0] div_cnt_reg, div_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    div_cnt_next = div_cnt_reg;
    tick_next = 1'b0;
    if (!en || baud_divisor == '0) begin
      div_cnt_next = '0;
    end else if (div_cnt_reg >= baud_divisor - 1'b1) begin
      div_cnt_next = '0;
      tick_next = 1'b1;
    end else begin
      div_cnt_next = div_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign baud_tick = tick_reg;

  // ----------------------------------------
  // Transmit bit capture
  // ----------------------------------------
  // The UART line is sampled mid-bit and queued; a full queue
  // drops the sample rather than corrupting an encoded period.
  logic cap_prev_reg, cap_prev_next;
  logic [3:0] cap_cnt_reg, cap_cnt_next;
  logic cap_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [0:0] fifo_out_data;

  always_comb begin
    cap_prev_next = uart_txd;
    cap_cnt_next = cap_cnt_reg;
    cap_push = 1'b0;
    if (!en) begin
      cap_cnt_next = ire_pkg::IRE_CNT_FIRST;
    end else if (uart_txd != cap_prev_reg) begin
      cap_cnt_next = ire_pkg::IRE_CNT_FIRST;
    end else if (tick_reg) begin
      cap_cnt_next = tick_inc(cap_cnt_reg);
      cap_push = (cap_cnt_reg == ire_pkg::IRE_CAP_SAMPLE_CNT) && fifo_in_ready;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cap_prev_reg <= ire_pkg::IRE_LINE_IDLE;
      cap_cnt_reg <= ire_pkg::IRE_CNT_FIRST;
    end else if (ce) begin
      cap_prev_reg <= cap_prev_next;
      cap_cnt_reg <= cap_cnt_next;
    end
  end

  assign tx_fifo_ready = fifo_in_ready;

  ire_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .flush(~en),
    .in_valid(cap_push),
    .in_ready(fifo_in_ready),
    .in_data(cap_prev_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // Encoder
  // ----------------------------------------
  logic [3:0] enc_cnt_reg, enc_cnt_next;
  logic enc_bit_reg, enc_bit_next;
  logic enc_mod_reg, enc_mod_next;

  // A new bit is taken only at the period boundary
  assign fifo_out_ready = en & tick_reg & (enc_cnt_reg == ire_pkg::IRE_CNT_LAST);

  always_comb begin
    enc_cnt_next = enc_cnt_reg;
    enc_bit_next = enc_bit_reg;
    enc_mod_next = enc_mod_reg;
    if (!en) begin
      enc_cnt_next = ire_pkg::IRE_CNT_LAST;
      enc_bit_next = ire_pkg::IRE_LINE_IDLE;
      enc_mod_next = ire_pkg::IRE_MOD_IDLE;
    end else if (tick_reg) begin
      enc_cnt_next = tick_inc(enc_cnt_reg);
      if (enc_cnt_reg == ire_pkg::IRE_CNT_LAST) begin
        // Empty queue idles as a stream of ones
        enc_bit_next = fifo_out_valid ? fifo_out_data[0] : ire_pkg::IRE_LINE_IDLE;
      end
      enc_mod_next = ~enc_bit_next
                     & in_range(enc_cnt_next, ire_pkg::IRE_TX_PULSE_FIRST, ire_pkg::IRE_TX_PULSE_LAST);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enc_cnt_reg <= ire_pkg::IRE_CNT_LAST;
      enc_bit_reg <= ire_pkg::IRE_LINE_IDLE;
      enc_mod_reg <= ire_pkg::IRE_MOD_IDLE;
    end else if (ce) begin
      enc_cnt_reg <= enc_cnt_next;
      enc_bit_reg <= enc_bit_next;
      enc_mod_reg <= enc_mod_next;
    end
  end

  assign ir_modulated_out = enc_mod_reg;
  // receiver deaf while a zero goes out
  assign tx_busy = ~enc_bit_reg | enc_mod_reg;
  assign tx_sending = ~enc_bit_reg;

  // ----------------------------------------
  // Decoder
  // ----------------------------------------
  ire_pkg::ire_rx_state_t rx_state_reg, rx_state_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic rx_prev_reg, rx_prev_next;
  logic rx_win_reg, rx_win_next;
  logic rx_zero_reg, rx_zero_next;
  logic rx_bit_reg, rx_bit_next;
  logic rx_fall;
  logic [3:0] rx_cnt_inc;

  assign rx_fall = rx_prev_reg & ~ir_pulse_in & ~tx_busy;
  assign rx_cnt_inc = tick_inc(rx_cnt_reg);

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_prev_next = ir_pulse_in;
    rx_win_next = rx_win_reg;
    rx_zero_next = rx_zero_reg;
    rx_bit_next = rx_bit_reg;
    if (!en) begin
      rx_state_next = ire_pkg::ire_rx_idle;
      rx_cnt_next = ire_pkg::IRE_CNT_FIRST;
      rx_win_next = 1'b0;
      rx_zero_next = 1'b0;
      rx_bit_next = ire_pkg::IRE_LINE_IDLE;
    end else begin
      case (rx_state_reg)
        ire_pkg::ire_rx_idle: begin
          if (rx_fall) begin
            rx_state_next = ire_pkg::ire_rx_track;
            rx_cnt_next = ire_pkg::IRE_CNT_FIRST;
            rx_zero_next = 1'b1;
            rx_win_next = 1'b0;
          end
        end
        ire_pkg::ire_rx_track: begin
          if (rx_fall && rx_win_reg) begin
            rx_cnt_next = ire_pkg::IRE_CNT_FIRST;
            rx_zero_next = 1'b1;
            rx_win_next = 1'b0;
          end else if (tick_reg) begin
            rx_cnt_next = rx_cnt_inc;
            if (rx_cnt_inc == ire_pkg::IRE_RX_WIN_OPEN_CNT) begin
              rx_win_next = 1'b1;
            end
            if (rx_cnt_inc == ire_pkg::IRE_RX_UPDATE_CNT) begin
              rx_bit_next = ~rx_zero_reg;
              rx_zero_next = 1'b0;
              rx_win_next = 1'b0;
              if (!rx_zero_reg) begin
                rx_state_next = ire_pkg::ire_rx_idle;
              end
            end
          end
        end
        default: begin
          rx_state_next = ire_pkg::ire_rx_idle;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg <= ire_pkg::ire_rx_idle;
      rx_cnt_reg <= ire_pkg::IRE_CNT_FIRST;
      rx_prev_reg <= ire_pkg::IRE_LINE_IDLE;
      rx_win_reg <= 1'b0;
      rx_zero_reg <= 1'b0;
      rx_bit_reg <= ire_pkg::IRE_LINE_IDLE;
    end else if (ce) begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_prev_reg <= rx_prev_next;
      rx_win_reg <= rx_win_next;
      rx_zero_reg <= rx_zero_next;
      rx_bit_reg <= rx_bit_next;
    end
  end

  assign rx_tracking = (rx_state_reg == ire_pkg::ire_rx_track);

  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  // Registered so switching the enable cannot glitch the pins.
  // The decoded level only changes at count eight, so resync
  // never bends a bit the UART is already sampling.
  logic txd_pin_reg, txd_pin_next;
  logic uart_rxd_reg, uart_rxd_next;

  always_comb begin
    txd_pin_next = en ? ir_modulated_out : uart_txd;
    // With the codec enabled, UART sees only steady decoded bits; disabled, it sees rxd_pin
    uart_rxd_next = en ? rx_bit_reg : rxd_pin;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txd_pin_reg <= ire_pkg::IRE_LINE_IDLE;
      uart_rxd_reg <= ire_pkg::IRE_LINE_IDLE;
    end else if (ce) begin
      txd_pin_reg <= txd_pin_next;
      uart_rxd_reg <= uart_rxd_next;
    end
  end

  assign txd_pin = txd_pin_reg;
  assign uart_rxd = uart_rxd_reg;

endmodule
`default_nettype wire

// file: sim/ire_endec_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ire_endec_sva #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic infrared_codec_enable,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic uart_txd,
  input wire logic uart_rxd,
  input wire logic txd_pin,
  input wire logic rxd_pin,
  input wire logic baud_tick,
  input wire logic tx_fifo_ready,
  input wire logic tx_sending,
  input wire logic rx_tracking
);
  // ----------------------------------------
  // Cycles since the last baud tick, and tick counts since the last txd_pin edge and the last rxd_pin fall
  // ----------------------------------------
  logic [DIV_W-1:0] gap_reg, gap_next;
  logic [4:0] txc_reg, txc_next, rxc_reg, rxc_next;
  logic seen_reg, seen_next, txa_reg, txa_next, rxa_reg, rxa_next;
  logic tpv_reg, rpv_reg, t_chg, r_fall, en;
  always_comb begin
    en = infrared_codec_enable;
    t_chg = txd_pin ^ tpv_reg;
    r_fall = rpv_reg & ~rxd_pin;
    gap_next = baud_tick ? DIV_W'(1) : gap_reg + DIV_W'(1);
    seen_next = en & (seen_reg | baud_tick);
    txc_next = t_chg ? {4'h0, baud_tick} : txc_reg + {4'h0, baud_tick};
    rxc_next = r_fall ? 5'h00 : rxc_reg + {4'h0, baud_tick};
    // Armed only after a full edge seen, so mode switches are not judged
    txa_next = en & (txa_reg | (txd_pin & ~tpv_reg));
    rxa_next = en & (rxa_reg | r_fall);
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {gap_reg, txc_reg, rxc_reg, seen_reg, txa_reg, rxa_reg, tpv_reg, rpv_reg} <= '0;
    end else begin
      {gap_reg, txc_reg, rxc_reg, seen_reg, txa_reg, rxa_reg, tpv_reg, rpv_reg} <=
        {gap_next, txc_next, rxc_next, seen_next, txa_next, rxa_next, txd_pin, rxd_pin};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_tx_rise;
    en && txa_reg && $rose(txd_pin);
  endsequence
  sequence s_tx_fall;
    en && txa_reg && $fell(txd_pin);
  endsequence
  sequence s_rx_fall;
    en && rxa_reg && $fell(uart_rxd);
  endsequence
  sequence s_rx_rise;
    en && rxa_reg && $rose(uart_rxd);
  endsequence
  AST_TICK_PERIOD: assert property (baud_tick && seen_reg |-> gap_reg == baud_divisor)
    else $error("baud tick spacing differs from divisor");
  AST_TICK_OFF: assert property (!en |=> !baud_tick)
    else $error("baud tick while codec off");
  AST_PASS_TX: assert property (!en && !$past(en) && $past(ce) |-> txd_pin == $past(uart_txd))
    else $error("transmit pass-through wrong");
  AST_PASS_RX: assert property (!en && !$past(en) && $past(ce) |-> uart_rxd == $past(rxd_pin))
    else $error("receive pass-through wrong");
  AST_PULSE_HIGH: assert property (s_tx_fall |-> txc_reg == 5'd3)
    else $error("pulse not three ticks wide");
  AST_PULSE_GAP: assert property (s_tx_rise |-> txc_reg[3:0] == 4'hd)
    else $error("pulse spacing off the bit grid");
  AST_RX_LAG: assert property (s_rx_fall |-> rxc_reg == 5'd8 && rx_tracking)
    else $error("decoded zero not eight ticks after edge");
  AST_RX_ONE: assert property (s_rx_rise |-> rxc_reg == 5'd24 && !rx_tracking)
    else $error("decoded one not at window close");
  AST_HALF_DUPLEX: assert property ($rose(rx_tracking) |-> !$past(tx_sending))
    else $error("receive started while sending");
endmodule
bind ire_endec ire_endec_sva #(.DIV_W(DIV_W)) ire_endec_sva_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
  .infrared_codec_enable(infrared_codec_enable), .baud_divisor(baud_divisor), .uart_txd(uart_txd),
  .uart_rxd(uart_rxd), .txd_pin(txd_pin), .rxd_pin(rxd_pin), .baud_tick(baud_tick),
  .tx_fifo_ready(tx_fifo_ready), .tx_sending(tx_sending), .rx_tracking(rx_tracking));
`default_nettype wire

// file: sim/ire_xcvr_model.sv
`timescale 1ns/1ps
`default_nettype none
module ire_xcvr_model (
  input wire logic sys_clk,
  input wire logic baud_tick,
  input wire logic txd_pin,
  output logic rxd_pin
);
  // ----------------------------------------
  // Optical side of the transceiver
  // ----------------------------------------
  int pulse_cnt = 0;
  logic prev = 1'b0;
  initial rxd_pin = 1'b1;
  always @(posedge sys_clk) begin
    if (txd_pin && !prev) pulse_cnt <= pulse_cnt + 1;
    prev <= txd_pin;
  end
  task automatic send(input logic [9:0] bits);
    for (int i = 0; i < 10; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge sys_clk iff baud_tick);
        rxd_pin <= !(bits[i] == 1'b0 && t >= 7 && t <= 9);
      end
    end
  endtask
endmodule
`default_nettype wire

// file: sim/ire_endec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ire_endec_tb;
  localparam int DIV = 3;
  logic sys_clk, nrst, ce, en, uart_txd, tb_rx, rx_low;
  logic [15:0] baud_divisor;
  logic uart_rxd, txd_pin, baud_tick, tx_fifo_ready, tx_sending, rx_tracking, model_rx;
  wire logic rxd_pin;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  assign rxd_pin = en ? model_rx : tb_rx;
  ire_endec ire_endec_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .infrared_codec_enable(en),
    .baud_divisor(baud_divisor), .uart_txd(uart_txd), .uart_rxd(uart_rxd), .txd_pin(txd_pin),
    .rxd_pin(rxd_pin), .baud_tick(baud_tick), .tx_fifo_ready(tx_fifo_ready), .tx_sending(tx_sending),
    .rx_tracking(rx_tracking));
  ire_xcvr_model ire_xcvr_model_inst (.sys_clk(sys_clk), .baud_tick(baud_tick), .txd_pin(txd_pin),
    .rxd_pin(model_rx));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [9:0] frame(input logic [7:0] b);
    return {1'b1, b, 1'b0};
  endfunction
  function automatic logic [15:0] zeros(input logic [9:0] f);
    zeros = 16'h0000;
    for (int i = 0; i < 10; i++) zeros += {15'h0000, ~f[i]};
  endfunction
  task automatic tx_frame(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      uart_txd <= f[i];
      repeat (16 * DIV - 1) @(posedge sys_clk);
    end
  endtask
  task automatic rx_frame(input logic [9:0] f);
    logic [9:0] got;
    fork
      ire_xcvr_model_inst.send(f);
      begin
        // Sample four ticks into each decoded bit
        repeat (20) @(posedge sys_clk iff baud_tick);
        for (int i = 0; i < 10; i++) begin
          #1 got[i] = uart_rxd;
          repeat (16) @(posedge sys_clk iff baud_tick);
        end
      end
    join
    chk_val("rx_frame", {6'h00, f}, {6'h00, got});
  endtask
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (en && uart_rxd === 1'b0) rx_low <= 1'b1;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    logic [15:0] c0;
    logic a, b, pa, pb;
    logic [7:0] v [6];
    nrst = 1'b0;
    ce = 1'b1;
    en = 1'b0;
    uart_txd = 1'b1;
    tb_rx = 1'b1;
    rx_low = 1'b0;
    baud_divisor = 16'(DIV);
    void'($urandom(83607));
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      a = 1'($urandom);
      b = 1'($urandom);
      uart_txd <= a;
      tb_rx <= b;
      #1;
      if (i > 0) begin
        chk_val("txd_pin", {15'h0, pa}, {15'h0, txd_pin});
        chk_val("uart_rxd", {15'h0, pb}, {15'h0, uart_rxd});
        chk_val("baud_tick", 16'h0, {15'h0, baud_tick});
      end
      pa = a;
      pb = b;
    end
    // Low clock enable must hold the pins
    @(posedge sys_clk);
    ce <= 1'b0;
    uart_txd <= ~pa;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_val("txd_pin_frozen", {15'h0, pa}, {15'h0, txd_pin});
    @(posedge sys_clk);
    ce <= 1'b1;
    @(posedge sys_clk);
    uart_txd <= 1'b1;
    tb_rx <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // divisor and idle line settled first
    en <= 1'b1;
    repeat (40 * DIV) @(posedge sys_clk);
    v = '{8'h00, 8'hff, 8'h55, 8'h00, 8'h00, 8'h00};
    for (int i = 3; i < 6; i++) v[i] = 8'($urandom);
    foreach (v[i]) begin
      c0 = 16'(ire_xcvr_model_inst.pulse_cnt);
      tx_frame(frame(v[i]));
      repeat (32 * DIV) @(posedge sys_clk);
      chk_val("pulses", zeros(frame(v[i])), 16'(ire_xcvr_model_inst.pulse_cnt) - c0);
      chk_val("tx_fifo_ready", 16'h1, {15'h0, tx_fifo_ready});
      chk_val("tx_sending", 16'h0, {15'h0, tx_sending});
    end
    // Incoming pulses during a zero-bit burst must be ignored
    rx_low = 1'b0;
    fork
      tx_frame(frame(8'h00));
      begin
        for (int k = 0; k < 400 && tx_sending !== 1'b1; k++) @(posedge sys_clk);
        ire_xcvr_model_inst.send(10'h3f0);
      end
    join
    repeat (32 * DIV) @(posedge sys_clk);
    chk_val("rx_low", 16'h0, {15'h0, rx_low});
    v = '{8'h00, 8'hff, 8'ha5, 8'h00, 8'h00, 8'h00};
    for (int i = 3; i < 6; i++) v[i] = 8'($urandom);
    foreach (v[i]) begin
      rx_frame(frame(v[i]));
      repeat (32 * DIV) @(posedge sys_clk);
      chk_val("rx_tracking", 16'h0, {15'h0, rx_tracking});
    end
    @(posedge sys_clk);
    en <= 1'b0;
    repeat (10) @(posedge sys_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
